//--- design/insn_decode_pkg.sv
package insn_decode_pkg;

    // ========================================
    // condition codes
    localparam logic [3:0] COND_EQ        = 4'h0;
    localparam logic [3:0] COND_NE        = 4'h1;
    localparam logic [3:0] COND_CS        = 4'h2;
    localparam logic [3:0] COND_CC        = 4'h3;
    localparam logic [3:0] COND_HI        = 4'h4;
    localparam logic [3:0] COND_LS        = 4'h5;
    localparam logic [3:0] COND_GT        = 4'h6;
    localparam logic [3:0] COND_LE        = 4'h7;
    localparam logic [3:0] COND_FS        = 4'h8;
    localparam logic [3:0] COND_FC        = 4'h9;
    localparam logic [3:0] COND_LO        = 4'hA;
    localparam logic [3:0] COND_HS        = 4'hB;
    localparam logic [3:0] COND_LT        = 4'hC;
    localparam logic [3:0] COND_GE        = 4'hD;
    localparam logic [3:0] COND_TRUE      = 4'hE;
    localparam logic [3:0] COND_FALSE     = 4'hF;

    // ========================================
    // format 2 operation codes
    localparam logic [2:0] F2_ADD_QUICK   = 3'h0;
    localparam logic [2:0] F2_CMP_QUICK   = 3'h1;
    localparam logic [2:0] F2_SAVE_COND0  = 3'h2;
    localparam logic [2:0] F2_SAVE_COND1  = 3'h3;
    localparam logic [2:0] F2_ADD_CMP_BR  = 3'h4;
    localparam logic [2:0] F2_MOVE_QUICK  = 3'h5;

    // ========================================
    // dedicated register selectors
    localparam logic [3:0] SEL_USER_STATE = 4'h0;
    localparam logic [3:0] SEL_FRAME_PTR  = 4'h8;
    localparam logic [3:0] SEL_STACK_PTR  = 4'h9;
    localparam logic [3:0] SEL_STATIC_BASE = 4'hA;
    localparam logic [3:0] SEL_PROC_STATE = 4'hD;
    localparam logic [3:0] SEL_VECTOR_BASE = 4'hE;
    localparam logic [3:0] SEL_SEGMENT    = 4'hF;

    // ========================================
    // format 3 trap code and float type values
    localparam logic [3:0] F3_TRAP_CODE   = 4'h8;
    localparam logic       FTYPE_SINGLE   = 1'b1;
    localparam logic       FTYPE_LONG     = 1'b0;

    // undefined float opcode selection
    localparam logic [1:0] UFOP_NONE      = 2'h0;
    localparam logic [1:0] UFOP_MOVE      = 2'h1;
    localparam logic [1:0] UFOP_ADD       = 2'h2;
    localparam logic [1:0] UFOP_COMPARE   = 2'h3;

    typedef enum logic [6:0] {
        DREG_NONE        = 7'b0000000,
        DREG_USER_STATE  = 7'b0000001,
        DREG_FRAME_PTR   = 7'b0000010,
        DREG_STACK_PTR   = 7'b0000100,
        DREG_STATIC_BASE = 7'b0001000,
        DREG_PROC_STATE  = 7'b0010000,
        DREG_VECTOR_BASE = 7'b0100000,
        DREG_SEGMENT     = 7'b1000000
    } dreg_t;

    typedef enum logic [2:0] {
        ACC_NONE  = 3'b000,
        ACC_READ  = 3'b001,
        ACC_WRITE = 3'b010,
        ACC_RMW   = 3'b100
    } access_t;

    typedef enum logic [3:0] {
        EXEC_NONE     = 4'b0000,
        EXEC_MOVE_FLT = 4'b0001,
        EXEC_ADD_FLT  = 4'b0010,
        EXEC_COMPARE  = 4'b0100,
        EXEC_TRAP     = 4'b1000
    } exec_t;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic l;
        logic f;
    } flags_t;

    typedef struct packed {
        exec_t   exec;
        access_t acc1;
        access_t acc2;
        logic    is_64;
    } float_dec_t;

endpackage : insn_decode_pkg

//--- design/instruction_field_decoder.sv
// Overview of operation
// - code 1000 true when F set; 1001 true when F clear.
// - code 1100 true when N and Z zero; 1101 true when N or Z one.
// - code 1110 always true; code 1111 always false.
// - quick forms decode the short field as a signed 4-bit immediate.
// - save-condition decodes the short field as a condition code.
// - selector maps 0,8,9,A,D,E,F to the seven dedicated registers.
// - selectors 0001-0111, 1011, 1100 are reserved and map to no register.
// - first undefined float opcode acts as move: read, write, f-field width.
// - second undefined float opcode acts as add: read, read-modify-write.
// - third undefined float opcode acts as compare: read, read.
// - float-type field 1 selects 32-bit, 0 selects 64-bit data.
`timescale 1ns/10ps
`default_nettype none
module instruction_field_decoder
    import insn_decode_pkg::*;
#(
    parameter int IMM_W = 32
) (
    input  wire logic             core_clk_in,
    input  wire logic             reset_in,
    input  wire logic [3:0]       cond_in,
    input  wire flags_t           flags_in,
    input  wire logic [2:0]       fmt2_op_in,
    input  wire logic [3:0]       short_in,
    input  wire logic             fmt3_valid_in,
    input  wire logic [3:0]       fmt3_op_in,
    input  wire logic             dreg_valid_in,
    input  wire logic [1:0]       ufop_in,
    input  wire logic             ftype_in,
    output logic                  branch_taken_out,
    output logic                  save_cond_out,
    output logic                  quick_valid_out,
    output logic [IMM_W-1:0]      quick_imm_out,
    output logic                  short_is_cond_out,
    output dreg_t                 dreg_out,
    output logic                  dreg_reserved_out,
    output float_dec_t            float_dec_out,
    output logic                  undef_trap_out
);

    // ========================================
    // condition evaluation
    function automatic logic eval_cond(input logic [3:0] c, input flags_t fl);
        logic r;
        r = 1'b0;
        case (c)
            COND_EQ:    r = fl.z;
            COND_NE:    r = ~fl.z;
            COND_CS:    r = fl.c;
            COND_CC:    r = ~fl.c;
            COND_HI:    r = fl.l;
            COND_LS:    r = ~fl.l;
            COND_GT:    r = fl.n;
            COND_LE:    r = ~fl.n;
            COND_FS:    r = fl.f;
            COND_FC:    r = ~fl.f;
            COND_LO:    r = ~fl.l & ~fl.z;
            COND_HS:    r = fl.l | fl.z;
            COND_LT:    r = ~fl.n & ~fl.z;
            COND_GE:    r = fl.n | fl.z;
            COND_TRUE:  r = 1'b1;
            default:    r = 1'b0;
        endcase
        return r;
    endfunction

    logic             branch_taken_d, branch_taken_q;
    logic             save_cond_d, save_cond_q;
    logic             quick_valid_d, quick_valid_q;
    logic [IMM_W-1:0] quick_imm_d, quick_imm_q;
    logic             short_is_cond_d, short_is_cond_q;
    dreg_t            dreg_d, dreg_q;
    logic             dreg_res_d, dreg_res_q;
    float_dec_t       fdec_d, fdec_q;
    logic             trap_d, trap_q;
    logic             is_quick;
    logic             is_scond;

    // ========================================
    // next-value decode
    always_comb begin
        is_quick = (fmt2_op_in == F2_ADD_QUICK) || (fmt2_op_in == F2_CMP_QUICK) ||
                   (fmt2_op_in == F2_ADD_CMP_BR) || (fmt2_op_in == F2_MOVE_QUICK);
        is_scond = (fmt2_op_in == F2_SAVE_COND0) || (fmt2_op_in == F2_SAVE_COND1);
        branch_taken_d  = eval_cond(cond_in, flags_in);
        quick_valid_d   = is_quick;
        quick_imm_d     = '0;
        if (is_quick) begin
            quick_imm_d = {{(IMM_W-4){short_in[3]}}, short_in};
        end
        short_is_cond_d = is_scond;
        save_cond_d     = is_scond && eval_cond(short_in, flags_in);
        // dedicated register map
        dreg_d     = DREG_NONE;
        dreg_res_d = 1'b0;
        if (dreg_valid_in) begin
            case (short_in)
                SEL_USER_STATE:  dreg_d = DREG_USER_STATE;
                SEL_FRAME_PTR:   dreg_d = DREG_FRAME_PTR;
                SEL_STACK_PTR:   dreg_d = DREG_STACK_PTR;
                SEL_STATIC_BASE: dreg_d = DREG_STATIC_BASE;
                SEL_PROC_STATE:  dreg_d = DREG_PROC_STATE;
                SEL_VECTOR_BASE: dreg_d = DREG_VECTOR_BASE;
                SEL_SEGMENT:     dreg_d = DREG_SEGMENT;
                default:         dreg_res_d = 1'b1;
            endcase
        end
        // undefined float opcodes
        fdec_d.exec  = EXEC_NONE;
        fdec_d.acc1  = ACC_NONE;
        fdec_d.acc2  = ACC_NONE;
        fdec_d.is_64 = (ftype_in == FTYPE_LONG);
        case (ufop_in)
            UFOP_MOVE: begin
                fdec_d.exec = EXEC_MOVE_FLT;
                fdec_d.acc1 = ACC_READ;
                fdec_d.acc2 = ACC_WRITE;
            end
            UFOP_ADD: begin
                fdec_d.exec = EXEC_ADD_FLT;
                fdec_d.acc1 = ACC_READ;
                fdec_d.acc2 = ACC_RMW;
            end
            UFOP_COMPARE: begin
                fdec_d.exec = EXEC_COMPARE;
                fdec_d.acc1 = ACC_READ;
                fdec_d.acc2 = ACC_READ;
            end
            default: begin
                fdec_d.exec = EXEC_NONE;
            end
        endcase
        trap_d = fmt3_valid_in && (fmt3_op_in[0] || (fmt3_op_in == F3_TRAP_CODE));
        if (trap_d) begin
            fdec_d.exec = EXEC_TRAP;
        end
    end

    // ========================================
    // output registers
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            branch_taken_q  <= 1'b0;
            save_cond_q     <= 1'b0;
            quick_valid_q   <= 1'b0;
            quick_imm_q     <= '0;
            short_is_cond_q <= 1'b0;
            dreg_q          <= DREG_NONE;
            dreg_res_q      <= 1'b0;
            fdec_q          <= '0;
            trap_q          <= 1'b0;
        end else begin
            branch_taken_q  <= branch_taken_d;
            save_cond_q     <= save_cond_d;
            quick_valid_q   <= quick_valid_d;
            quick_imm_q     <= quick_imm_d;
            short_is_cond_q <= short_is_cond_d;
            dreg_q          <= dreg_d;
            dreg_res_q      <= dreg_res_d;
            fdec_q          <= fdec_d;
            trap_q          <= trap_d;
        end
    end

    assign branch_taken_out  = branch_taken_q;
    assign save_cond_out     = save_cond_q;
    assign quick_valid_out   = quick_valid_q;
    assign quick_imm_out     = quick_imm_q;
    assign short_is_cond_out = short_is_cond_q;
    assign dreg_out          = dreg_q;
    assign dreg_reserved_out = dreg_res_q;
    assign float_dec_out     = fdec_q;
    assign undef_trap_out    = trap_q;

    // ========================================
    // checks
    a_flag_set_cond: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (cond_in == COND_FS) |=> (branch_taken_out == $past(flags_in.f)))
        else $error("flag set condition wrong");
    a_flag_clr_cond: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (cond_in == COND_FC) |=> (branch_taken_out != $past(flags_in.f)))
        else $error("flag clear condition wrong");
    a_less_than_cond: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (cond_in == COND_LT) |=>
        (branch_taken_out == !($past(flags_in.n) || $past(flags_in.z))))
        else $error("less than condition wrong");
    a_greater_eq_cond: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (cond_in == COND_GE) |=>
        (branch_taken_out == ($past(flags_in.n) || $past(flags_in.z))))
        else $error("greater or equal condition wrong");
    a_fixed_cond: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (cond_in[3:1] == 3'h7) |=> (branch_taken_out == !$past(cond_in[0])))
        else $error("fixed condition wrong");
    a_quick_sign: assert property (@(posedge core_clk_in) disable iff (reset_in)
        quick_valid_out |-> (quick_imm_out[3:0] == $past(short_in))
        && (quick_imm_out[IMM_W-1] == quick_imm_out[3]))
        else $error("quick immediate not sign extended");
    a_scond_use: assert property (@(posedge core_clk_in) disable iff (reset_in)
        ((fmt2_op_in == F2_SAVE_COND0) && (short_in == COND_TRUE)) |=>
        (save_cond_out && short_is_cond_out && !quick_valid_out))
        else $error("save condition without cond decode");
    a_dreg_segment: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (dreg_valid_in && short_in == SEL_SEGMENT) |=> (dreg_out == DREG_SEGMENT))
        else $error("segment selector wrong");
    a_dreg_reserved: assert property (@(posedge core_clk_in) disable iff (reset_in)
        dreg_reserved_out |-> (dreg_out == DREG_NONE))
        else $error("reserved selector mapped");
    a_dreg_res_flag: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (dreg_valid_in && ((short_in >= 4'h1 && short_in <= 4'h7) ||
        short_in == 4'hB || short_in == 4'hC)) |=> dreg_reserved_out)
        else $error("reserved selector not flagged");
    a_move_access: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (float_dec_out.exec == EXEC_MOVE_FLT) |-> (float_dec_out.acc2 == ACC_WRITE))
        else $error("move access class wrong");
    a_add_access: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (float_dec_out.exec == EXEC_ADD_FLT) |-> (float_dec_out.acc2 == ACC_RMW))
        else $error("add access class wrong");
    a_cmp_access: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (float_dec_out.exec == EXEC_COMPARE) |-> (float_dec_out.acc1 == ACC_READ)
        && (float_dec_out.acc2 == ACC_READ))
        else $error("compare access class wrong");
    a_float_width: assert property (@(posedge core_clk_in) disable iff (reset_in)
        1'b1 |=> (float_dec_out.is_64 == !$past(ftype_in)))
        else $error("float width wrong");
    a_undef_trap: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (fmt3_valid_in && fmt3_op_in == F3_TRAP_CODE) |=> undef_trap_out
        && (float_dec_out.exec == EXEC_TRAP))
        else $error("undefined format 3 not trapped");

endmodule // instruction_field_decoder
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import insn_decode_pkg::*;

    // ========================================
    // stimulus vector, same order as the input concat
    typedef struct packed {
        logic       rst;
        logic [3:0] cond;
        flags_t     flags;
        logic [2:0] op2;
        logic [3:0] shrt;
        logic       f3v;
        logic [3:0] f3op;
        logic       dv;
        logic [1:0] ufop;
        logic       ft;
    } vec_t;

    logic        core_clk_in;
    logic        reset_in;
    logic [3:0]  cond_in;
    flags_t      flags_in;
    logic [2:0]  fmt2_op_in;
    logic [3:0]  short_in;
    logic        fmt3_valid_in;
    logic [3:0]  fmt3_op_in;
    logic        dreg_valid_in;
    logic [1:0]  ufop_in;
    logic        ftype_in;
    logic        branch_taken_out;
    logic        save_cond_out;
    logic        quick_valid_out;
    logic [31:0] quick_imm_out;
    logic        short_is_cond_out;
    dreg_t       dreg_out;
    logic        dreg_reserved_out;
    float_dec_t  float_dec_out;
    logic        undef_trap_out;
    int          err_count;
    int          n_checks;
    int          cycles;
    int          seed;
    vec_t        prev_v;
    vec_t        v;

    instruction_field_decoder #(.IMM_W(32)) i_instruction_field_decoder (
        .core_clk_in(core_clk_in), .reset_in(reset_in), .cond_in(cond_in),
        .flags_in(flags_in), .fmt2_op_in(fmt2_op_in), .short_in(short_in),
        .fmt3_valid_in(fmt3_valid_in), .fmt3_op_in(fmt3_op_in),
        .dreg_valid_in(dreg_valid_in), .ufop_in(ufop_in), .ftype_in(ftype_in),
        .branch_taken_out(branch_taken_out), .save_cond_out(save_cond_out),
        .quick_valid_out(quick_valid_out), .quick_imm_out(quick_imm_out),
        .short_is_cond_out(short_is_cond_out), .dreg_out(dreg_out),
        .dreg_reserved_out(dreg_reserved_out), .float_dec_out(float_dec_out),
        .undef_trap_out(undef_trap_out)
    );

    // ========================================
    // clock and hang guard
    initial core_clk_in = 1'b0;
    always #5 core_clk_in = ~core_clk_in;

    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles >= 4000) begin
            err_count++;
            close_out();
        end
    end

    // ========================================
    // expectation functions
    function automatic logic ev(input logic [3:0] c, input flags_t f);
        logic [15:0] t;
        t = {1'b0, 1'b1, f.n | f.z, ~(f.n | f.z), f.l | f.z, ~(f.l | f.z), ~f.f, f.f,
             ~f.n, f.n, ~f.l, f.l, ~f.c, f.c, ~f.z, f.z};
        return t[c];
    endfunction

    function automatic dreg_t dmap(input logic [3:0] s);
        case (s)
            4'h0: return DREG_USER_STATE;
            4'h8: return DREG_FRAME_PTR;
            4'h9: return DREG_STACK_PTR;
            4'hA: return DREG_STATIC_BASE;
            4'hD: return DREG_PROC_STATE;
            4'hE: return DREG_VECTOR_BASE;
            4'hF: return DREG_SEGMENT;
            default: return DREG_NONE;
        endcase
    endfunction

    // ========================================
    // compare and closing
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // checks outputs against inputs sampled at the latest edge
    task automatic check(input vec_t p);
        logic       q;
        logic       sc;
        logic       tr;
        logic       rv;
        logic [3:0] ex;
        logic [2:0] a1;
        logic [2:0] a2;
        rv = ~p.rst;
        q  = (p.op2 inside {3'h0, 3'h1, 3'h4, 3'h5}) && rv;
        sc = (p.op2 inside {3'h2, 3'h3}) && rv;
        tr = p.f3v && (p.f3op[0] || p.f3op == 4'h8) && rv;
        case (p.ufop)
            2'h1: {ex, a1, a2} = {EXEC_MOVE_FLT, ACC_READ, ACC_WRITE};
            2'h2: {ex, a1, a2} = {EXEC_ADD_FLT, ACC_READ, ACC_RMW};
            2'h3: {ex, a1, a2} = {EXEC_COMPARE, ACC_READ, ACC_READ};
            default: {ex, a1, a2} = 10'h000;
        endcase
        if (tr) ex = EXEC_TRAP;
        if (!rv) {ex, a1, a2} = 10'h000;
        cmp(32'(branch_taken_out), 32'(ev(p.cond, p.flags) & rv));
        cmp(32'(quick_valid_out), 32'(q));
        cmp(quick_imm_out, q ? {{28{p.shrt[3]}}, p.shrt} : 32'h0);
        cmp(32'(short_is_cond_out), 32'(sc));
        cmp(32'(save_cond_out), 32'(sc & ev(p.shrt, p.flags)));
        cmp(32'(dreg_out), 32'((p.dv && rv) ? dmap(p.shrt) : DREG_NONE));
        cmp(32'(dreg_reserved_out), 32'(p.dv && rv && dmap(p.shrt) == DREG_NONE));
        cmp(32'(float_dec_out), 32'({ex, a1, a2, ~p.ft & rv}));
        cmp(32'(undef_trap_out), 32'(tr));
    endtask

    // drives a new set at the edge, then checks the set before it
    task automatic step(input vec_t nv);
        @(posedge core_clk_in);
        {reset_in, cond_in, flags_in, fmt2_op_in, short_in, fmt3_valid_in, fmt3_op_in,
         dreg_valid_in, ufop_in, ftype_in} <= nv;
        #1;
        check(prev_v);
        prev_v = nv;
    endtask

    // ========================================
    // main sequence: reset, exhaustive corners, random with rare resets
    initial begin
        seed = 20484;
        err_count = 0;
        n_checks = 0;
        cycles = 0;
        prev_v = '0;
        prev_v.rst = 1'b1;
        {reset_in, cond_in, flags_in, fmt2_op_in, short_in, fmt3_valid_in, fmt3_op_in,
         dreg_valid_in, ufop_in, ftype_in} = prev_v;
        repeat (4) step(prev_v);
        for (int i = 0; i < 512; i++) begin
            v = '0;
            v.cond = i[3:0];
            v.flags = i[8:4];
            v.shrt = i[3:0];
            v.op2 = i[6:4];
            v.dv = i[4];
            v.f3v = i[7];
            v.f3op = i[3:0];
            v.ufop = i[5:4];
            v.ft = i[8];
            step(v);
        end
        for (int i = 0; i < 2000; i++) begin
            v = vec_t'(26'($random(seed)));
            v.rst = (($random(seed) & 63) == 0);
            step(v);
        end
        step(v);
        close_out();
    end
endmodule // tb
`default_nettype wire
